// [bsls_sequencer.sv]
// Branch, skip and load instruction sequencer of the 8-bit core
//
// Notes on behaviour
// RULE1 - Equal registers skip next instruction, 1/2/3 cycles
// RULE2 - Register bit clear/set skips, flags untouched
// RULE3 - I/O bit skips take one extra cycle
// RULE4 - Status-bit branch to pc plus offset plus one
// RULE5 - Signed ge/lt branch on N xor V
// RULE6 - Carry branches, including unsigned aliases
// RULE7 - Half-carry branch pair
// RULE8 - User transfer bit branch pair
// RULE9 - Overflow branch pair, 1 or 2 cycles
// RULE10 - Interrupt enable branch pair, same timing
// RULE11 - Direct load, 16-bit address, two cycles
// RULE12 - Post-increment load, pointer plus one, one cycle
// RULE13 - Pre-decrement load, pointer minus one first, two cycles
`timescale 1ns/1ps
`include "bsls_params.svh"

module bsls_sequencer (
   input  wire logic                 clk,
   input  wire logic                 reset_n,
   input  wire logic                 instr_valid,
   input  wire bsls_pkg::bsls_instr_t instr,
   input  wire logic [7:0]           status_register,
   input  wire logic [7:0]           mem_rdata,
   output logic                      ready,
   output logic                      pc_valid,
   output logic [15:0]               pc_next,
   output logic                      mem_rd,
   output logic [15:0]               mem_addr,
   output bsls_pkg::bsls_wb_t        wb
);
   import bsls_pkg::*;

   bsls_regs_t r_q;
   bsls_regs_t r_d;

   logic        cond;
   logic        is_skip;
   logic        is_io;
   logic        is_branch;
   logic [15:0] seq_pc;
   logic [15:0] skip_pc;
   logic [15:0] br_pc;
   logic [2:0]  cycles;

   // ==========================================================
   // Condition evaluation
   always_comb begin
      cond      = 1'b0;
      is_skip   = 1'b0;
      is_io     = 1'b0;
      is_branch = 1'b0;
      case (instr.op)
         BSLS_OP_COMPARE_SKIP_EQUAL: begin
            cond    = (instr.opa == instr.opb); // RULE1
            is_skip = 1'b1;
         end
         BSLS_OP_SKIP_REG_BIT_CLEAR: begin
            cond    = ~instr.opa[instr.bit_sel]; // RULE2
            is_skip = 1'b1;
         end
         BSLS_OP_SKIP_REG_BIT_SET: begin
            cond    = instr.opa[instr.bit_sel]; // RULE2
            is_skip = 1'b1;
         end
         BSLS_OP_SKIP_IO_BIT_CLEAR: begin
            cond    = ~instr.opa[instr.bit_sel]; // RULE3
            is_skip = 1'b1;
            is_io   = 1'b1;
         end
         BSLS_OP_SKIP_IO_BIT_SET: begin
            cond    = instr.opa[instr.bit_sel]; // RULE3
            is_skip = 1'b1;
            is_io   = 1'b1;
         end
         BSLS_OP_BRANCH_FLAG_ONE: begin
            cond      = status_register[instr.bit_sel]; // RULE4
            is_branch = 1'b1;
         end
         BSLS_OP_BRANCH_FLAG_ZERO: begin
            cond      = ~status_register[instr.bit_sel]; // RULE4
            is_branch = 1'b1;
         end
         BSLS_OP_BRANCH_SIGNED_GE: begin
            cond      = ~(status_register[`BSLS_SR_N] ^ status_register[`BSLS_SR_V]); // RULE5
            is_branch = 1'b1;
         end
         BSLS_OP_BRANCH_SIGNED_LT: begin
            cond      = status_register[`BSLS_SR_N] ^ status_register[`BSLS_SR_V]; // RULE5
            is_branch = 1'b1;
         end
         BSLS_OP_BRANCH_CARRY_ZERO: begin
            cond      = ~status_register[`BSLS_SR_C]; // RULE6
            is_branch = 1'b1;
         end
         BSLS_OP_BRANCH_CARRY_ONE: begin
            cond      = status_register[`BSLS_SR_C]; // RULE6
            is_branch = 1'b1;
         end
         BSLS_OP_BRANCH_HALFCARRY_ONE: begin
            cond      = status_register[`BSLS_SR_H]; // RULE7
            is_branch = 1'b1;
         end
         BSLS_OP_BRANCH_HALFCARRY_ZERO: begin
            cond      = ~status_register[`BSLS_SR_H]; // RULE7
            is_branch = 1'b1;
         end
         BSLS_OP_BRANCH_USERBIT_ONE: begin
            cond      = status_register[`BSLS_SR_T]; // RULE8
            is_branch = 1'b1;
         end
         BSLS_OP_BRANCH_USERBIT_ZERO: begin
            cond      = ~status_register[`BSLS_SR_T]; // RULE8
            is_branch = 1'b1;
         end
         BSLS_OP_BRANCH_OVERFLOW_ONE: begin
            cond      = status_register[`BSLS_SR_V]; // RULE9
            is_branch = 1'b1;
         end
         BSLS_OP_BRANCH_OVERFLOW_ZERO: begin
            cond      = ~status_register[`BSLS_SR_V]; // RULE9
            is_branch = 1'b1;
         end
         BSLS_OP_BRANCH_IRQ_ENABLED: begin
            cond      = status_register[`BSLS_SR_I]; // RULE10
            is_branch = 1'b1;
         end
         BSLS_OP_BRANCH_IRQ_DISABLED: begin
            cond      = ~status_register[`BSLS_SR_I]; // RULE10
            is_branch = 1'b1;
         end
         default: begin
            cond = 1'b0;
         end
      endcase
   end

   // ==========================================================
   // Target arithmetic; offset is sign-extended words
   assign seq_pc  = instr.pc + 16'h0001;
   assign skip_pc = instr.pc + (instr.next_long ? 16'h0003 : 16'h0002); // RULE1
   assign br_pc   = instr.pc + {{9{instr.offset[6]}}, instr.offset} + 16'h0001; // RULE4

   // Cycle count: skips add one per skipped word
   always_comb begin
      cycles = `BSLS_CYC_BR_NT;
      if (is_branch) begin
         cycles = cond ? `BSLS_CYC_BR_T : `BSLS_CYC_BR_NT; // RULE9
      end else if (is_skip) begin
         cycles = `BSLS_CYC_SKIP_NO; // RULE2
         if (cond) begin
            cycles = instr.next_long ? `BSLS_CYC_SKIP_W2 : `BSLS_CYC_SKIP_W1; // RULE1
         end
         if (is_io) begin
            cycles = cycles + `BSLS_CYC_IO_XTRA; // RULE3
         end
      end else if (instr.op == BSLS_OP_LOAD_DIRECT) begin
         cycles = `BSLS_CYC_LOAD_DIR; // RULE11
      end else if (instr.op == BSLS_OP_LOAD_INDIRECT_DEC) begin
         cycles = `BSLS_CYC_LOAD_DEC; // RULE13
      end else if (instr.op == BSLS_OP_LOAD_INDIRECT_INC) begin
         cycles = `BSLS_CYC_LOAD_INC; // RULE12
      end
   end

   // ==========================================================
   // Next-state logic; flags are never written here
   always_comb begin
      r_d          = r_q;
      r_d.pc_valid = 1'b0;
      r_d.mem_rd   = 1'b0;
      r_d.wb.valid = 1'b0;
      r_d.wb.ptr_we = 1'b0;
      case (r_q.state)
         BSLS_ST_IDLE: begin
            if (instr_valid && instr.op != BSLS_OP_NONE) begin
               r_d.ready  = 1'b0;
               r_d.cnt    = cycles - 3'd1;
               r_d.state  = BSLS_ST_BUSY;
               r_d.pc     = seq_pc;
               r_d.dest   = instr.dest;
               r_d.ptr_we = 1'b0;
               if ((is_branch || is_skip) && cond) begin
                  r_d.pc = is_branch ? br_pc : skip_pc; // RULE4
               end
               case (instr.op)
                  BSLS_OP_LOAD_DIRECT: begin
                     r_d.mem_rd   = 1'b1;
                     r_d.mem_addr = instr.addr; // RULE11
                  end
                  BSLS_OP_LOAD_INDIRECT_INC: begin
                     r_d.mem_rd   = 1'b1;
                     r_d.mem_addr = instr.addr; // RULE12
                     r_d.ptr      = instr.addr + 16'h0001; // RULE12
                     r_d.ptr_we   = 1'b1;
                  end
                  BSLS_OP_LOAD_INDIRECT_DEC: begin
                     r_d.mem_rd   = 1'b1;
                     r_d.mem_addr = instr.addr - 16'h0001; // RULE13
                     r_d.ptr      = instr.addr - 16'h0001; // RULE13
                     r_d.ptr_we   = 1'b1;
                  end
                  default: begin
                     r_d.mem_rd = 1'b0;
                  end
               endcase
               // Single-cycle ops finish at once
               if (cycles == 3'd1) begin
                  r_d.state    = BSLS_ST_IDLE;
                  r_d.ready    = 1'b1;
                  r_d.pc_valid = 1'b1;
               end
            end
         end
         BSLS_ST_BUSY: begin
            if (r_q.cnt <= 3'd1) begin
               r_d.state    = BSLS_ST_IDLE;
               r_d.ready    = 1'b1;
               r_d.pc_valid = 1'b1;
            end else begin
               r_d.cnt = r_q.cnt - 3'd1;
            end
         end
         default: begin
            r_d.state = BSLS_ST_IDLE;
            r_d.ready = 1'b1;
         end
      endcase
      // Memory answers in the read strobe cycle; write-back lands one cycle later
      if (r_q.mem_rd) begin
         r_d.wb.valid  = 1'b1;
         r_d.wb.dest   = r_q.dest;
         r_d.wb.data   = mem_rdata;
         r_d.wb.ptr_we = r_q.ptr_we;
         r_d.wb.ptr    = r_q.ptr;
      end
   end

   // ==========================================================
   // State register, synchronous reset
   always_ff @(posedge clk) begin
      if (!reset_n) begin
         r_q          <= '0;
         r_q.state    <= BSLS_ST_IDLE;
         r_q.ready    <= 1'b1;
         r_q.pc       <= `BSLS_PC_RST;
      end else begin
         r_q <= r_d;
      end
   end

   assign ready    = r_q.ready;
   assign pc_valid = r_q.pc_valid;
   assign pc_next  = r_q.pc;
   assign mem_rd   = r_q.mem_rd;
   assign mem_addr = r_q.mem_addr;
   assign wb       = r_q.wb;
endmodule

// [bsls_params.svh]
// Constants for the branch, skip and load sequencer
`ifndef BSLS_PARAMS_SVH
`define BSLS_PARAMS_SVH
// Status register bit positions
`define BSLS_SR_C 3'd0
`define BSLS_SR_Z 3'd1
`define BSLS_SR_N 3'd2
`define BSLS_SR_V 3'd3
`define BSLS_SR_S 3'd4
`define BSLS_SR_H 3'd5
`define BSLS_SR_T 3'd6
`define BSLS_SR_I 3'd7
// Cycle counts
`define BSLS_CYC_BR_NT   3'd1
`define BSLS_CYC_BR_T    3'd2
`define BSLS_CYC_SKIP_NO 3'd1
`define BSLS_CYC_SKIP_W1 3'd2
`define BSLS_CYC_SKIP_W2 3'd3
`define BSLS_CYC_IO_XTRA 3'd1
`define BSLS_CYC_LOAD_DIR 3'd2
`define BSLS_CYC_LOAD_INC 3'd1
`define BSLS_CYC_LOAD_DEC 3'd2
// Reset values
`define BSLS_PC_RST      16'h0000
`endif

// [bsls_pkg.sv]
// Types for the branch, skip and load sequencer
package bsls_pkg;
   typedef enum logic [4:0] {
      BSLS_OP_NONE,
      BSLS_OP_COMPARE_SKIP_EQUAL,
      BSLS_OP_SKIP_REG_BIT_CLEAR,
      BSLS_OP_SKIP_REG_BIT_SET,
      BSLS_OP_SKIP_IO_BIT_CLEAR,
      BSLS_OP_SKIP_IO_BIT_SET,
      BSLS_OP_BRANCH_FLAG_ONE,
      BSLS_OP_BRANCH_FLAG_ZERO,
      BSLS_OP_BRANCH_SIGNED_GE,
      BSLS_OP_BRANCH_SIGNED_LT,
      BSLS_OP_BRANCH_CARRY_ZERO,
      BSLS_OP_BRANCH_CARRY_ONE,
      BSLS_OP_BRANCH_HALFCARRY_ONE,
      BSLS_OP_BRANCH_HALFCARRY_ZERO,
      BSLS_OP_BRANCH_USERBIT_ONE,
      BSLS_OP_BRANCH_USERBIT_ZERO,
      BSLS_OP_BRANCH_OVERFLOW_ONE,
      BSLS_OP_BRANCH_OVERFLOW_ZERO,
      BSLS_OP_BRANCH_IRQ_ENABLED,
      BSLS_OP_BRANCH_IRQ_DISABLED,
      BSLS_OP_LOAD_DIRECT,
      BSLS_OP_LOAD_INDIRECT_INC,
      BSLS_OP_LOAD_INDIRECT_DEC
   } bsls_op_t;

   // Decoded instruction as handed in by the fetch stage
   typedef struct packed {
      bsls_op_t    op;
      logic [15:0] pc;        // address of this instruction
      logic [7:0]  opa;       // Rd / Rr value or I/O register value
      logic [7:0]  opb;       // Rr value for compare
      logic [2:0]  bit_sel;   // bit number or status flag number
      logic signed [6:0] offset; // branch displacement in words
      logic        next_long; // following instruction is two words
      logic [15:0] addr;      // direct address or pointer value
      logic [4:0]  dest;      // destination register number
   } bsls_instr_t;

   // Load result written back to the register file
   typedef struct packed {
      logic        valid;
      logic [4:0]  dest;
      logic [7:0]  data;
      logic        ptr_we;
      logic [15:0] ptr;
   } bsls_wb_t;

   typedef enum logic [1:0] {
      BSLS_ST_IDLE,
      BSLS_ST_BUSY
   } bsls_state_t;

   // All state of the sequencer
   typedef struct packed {
      bsls_state_t state;
      logic [2:0]  cnt;
      logic        ready;
      logic        pc_valid;
      logic [15:0] pc;
      logic        mem_rd;
      logic [15:0] mem_addr;
      bsls_wb_t    wb;
      logic [4:0]  dest;
      logic        ptr_we;
      logic [15:0] ptr;
   } bsls_regs_t;
endpackage

// [bsls_checker.sv]
// Port-level assertions for the branch, skip and load sequencer
`timescale 1ns/1ps
`include "bsls_params.svh"
module bsls_checker
   import bsls_pkg::*;
(
   input wire logic        clk,
   input wire logic        reset_n,
   input wire logic        instr_valid,
   input wire bsls_instr_t instr,
   input wire logic [7:0]  status_register,
   input wire logic [7:0]  mem_rdata,
   input wire logic        ready,
   input wire logic        pc_valid,
   input wire logic [15:0] pc_next,
   input wire logic        mem_rd,
   input wire logic [15:0] mem_addr,
   input wire bsls_wb_t    wb
);
   // =====
   // Helpers
   bsls_op_t    op;
   logic [7:0]  sr;
   logic [15:0] base_q, tgt_q, adr_q;
   assign op = (ready && instr_valid) ? instr.op : BSLS_OP_NONE;
   assign sr = status_register;
   // Latched at the take edge; safe since nothing new is taken while busy
   always_ff @(posedge clk) begin
      if (op != BSLS_OP_NONE) begin
         base_q <= instr.pc;
         tgt_q  <= instr.pc + {{9{instr.offset[6]}}, instr.offset} + 16'h0001;
         adr_q  <= instr.addr;
      end
   end
   default clocking cb @(posedge clk); endclocking
   default disable iff (!reset_n);
   // =====
   // Assertions
   skip_equal_a: assert property (op == BSLS_OP_COMPARE_SKIP_EQUAL
      && instr.opa == instr.opb
      && !instr.next_long |=> !pc_valid ##1 pc_valid && pc_next == base_q + 16'h0002)
      else $error("equal compare skip wrong");
   skip_bitclr_a: assert property (op == BSLS_OP_SKIP_REG_BIT_CLEAR
      && !instr.opa[instr.bit_sel] && instr.next_long
      |=> !pc_valid [*2] ##1 pc_valid && pc_next == base_q + 16'h0003)
      else $error("register bit skip wrong");
   io_noskip_a: assert property (op == BSLS_OP_SKIP_IO_BIT_SET
      && !instr.opa[instr.bit_sel]
      |=> !pc_valid ##1 pc_valid && pc_next == base_q + 16'h0001)
      else $error("io bit no-skip wrong");
   flag_branch_a: assert property (op == BSLS_OP_BRANCH_FLAG_ONE && sr[instr.bit_sel]
      |=> !pc_valid ##1 pc_valid && pc_next == tgt_q)
      else $error("status bit branch wrong");
   signed_ge_a: assert property (op == BSLS_OP_BRANCH_SIGNED_GE
      && (sr[`BSLS_SR_N] ^ sr[`BSLS_SR_V])
      |=> pc_valid && pc_next == base_q + 16'h0001)
      else $error("signed ge branch wrong");
   carry_zero_a: assert property (op == BSLS_OP_BRANCH_CARRY_ZERO && !sr[`BSLS_SR_C]
      |=> !pc_valid ##1 pc_valid && pc_next == tgt_q)
      else $error("carry branch wrong");
   load_dir_a: assert property (op == BSLS_OP_LOAD_DIRECT
      |=> mem_rd && mem_addr == adr_q ##1 wb.valid && pc_valid)
      else $error("direct load wrong");
   // A new instruction may be taken before this write-back lands, so use $past
   load_inc_a: assert property (op == BSLS_OP_LOAD_INDIRECT_INC
      |-> ##2 wb.valid && wb.ptr_we && wb.ptr == $past(instr.addr, 2) + 16'h0001)
      else $error("post-increment load wrong");
   load_dec_a: assert property (op == BSLS_OP_LOAD_INDIRECT_DEC
      |-> ##[1:2] mem_rd && mem_addr == adr_q - 16'h0001)
      else $error("pre-decrement load wrong");
endmodule

bind bsls_sequencer bsls_checker i_chk (.clk(clk), .reset_n(reset_n),
   .instr_valid(instr_valid), .instr(instr), .status_register(status_register),
   .mem_rdata(mem_rdata), .ready(ready), .pc_valid(pc_valid), .pc_next(pc_next),
   .mem_rd(mem_rd), .mem_addr(mem_addr), .wb(wb));

// [tb_top.sv]
// Self-checking testbench for the branch, skip and load sequencer
`timescale 1ns/1ps
module tb_top;
   import bsls_pkg::*;
   // =====
   // Stimulus and observation
   logic        clk, reset_n, instr_valid, ready, pc_valid, mem_rd;
   bsls_instr_t instr;
   logic [7:0]  sr, mem_rdata;
   logic [15:0] pc_next, mem_addr;
   bsls_wb_t    wb;
   int          fail_count, checks_done, cyc, n, nb, nr;
   bsls_sequencer i_dut (.clk(clk), .reset_n(reset_n), .instr_valid(instr_valid),
      .instr(instr), .status_register(sr), .mem_rdata(mem_rdata), .ready(ready),
      .pc_valid(pc_valid), .pc_next(pc_next), .mem_rd(mem_rd), .mem_addr(mem_addr), .wb(wb));
   // Data space: address-scrambled bytes, held while the address is held
   assign mem_rdata = mem_addr[7:0] ^ mem_addr[15:8] ^ 8'hA5;
   initial begin
      clk = 1'b0;
      forever #2 clk = ~clk;
   end
   // Cut a hang short; ceiling far above the few hundred cycles needed
   always @(posedge clk) begin
      cyc <= cyc + 1;
      if (cyc == 3000) begin
         fail_count++;
         conclude();
      end
   end
   task automatic chk(logic [31:0] seen, logic [31:0] exp);
      checks_done++;
      if (seen !== exp) begin
         fail_count++;
         $display("Error at %0t: saw %h expected %h", $time, seen, exp);
      end
   endtask
   // Offer one instruction; n counts cycles to the posted pc, nb busy, nr strobes
   task automatic run(bsls_op_t op, logic [7:0] a, logic [7:0] b, logic [2:0] bs,
                      logic [6:0] off, logic lng, logic [15:0] ad, logic [7:0] s);
      @(posedge clk);
      instr_valid <= 1'b1;
      instr       <= '{op, 16'h0020, a, b, bs, off, lng, ad, 5'h03};
      sr          <= s;
      @(posedge clk);
      instr_valid <= 1'b0;
      #1 n = 1;
      nb = int'(ready === 1'b0);
      nr = int'(mem_rd === 1'b1);
      while (pc_valid !== 1'b1 && n < 8) begin
         @(posedge clk);
         #1 n++;
         nb += int'(ready === 1'b0);
         nr += int'(mem_rd === 1'b1);
      end
   endtask
   // =====
   // Scenarios
   task automatic t_skip();
      bsls_op_t   op;
      logic       v, hit, lng;
      logic [2:0] bs;
      int         m;
      for (int j = 0; j < 20; j++) begin
         op  = bsls_op_t'(1 + j / 4);
         hit = j[0];
         lng = j[1];
         bs  = 3'(j);
         v   = (op == BSLS_OP_SKIP_REG_BIT_CLEAR || op == BSLS_OP_SKIP_IO_BIT_CLEAR) ^ hit;
         m   = hit ? 2 + lng : 1;
         run(op, op == BSLS_OP_COMPARE_SKIP_EQUAL ? 8'h3C : (v ? 8'h01 << bs : ~(8'h01 << bs)),
             hit ? 8'h3C : 8'h3D, bs, 7'h00, lng, 16'h0000, 8'hFF);
         chk(n, m + (op >= BSLS_OP_SKIP_IO_BIT_CLEAR));
         chk(nb, m + (op >= BSLS_OP_SKIP_IO_BIT_CLEAR) - 1);
         chk(pc_next, 16'h0020 + m);
      end
      $display("skip test finished");
   endtask
   task automatic t_branch();
      logic [7:0]  pat [4] = '{8'h00, 8'hFF, 8'h55, 8'hAA};
      int          fb [5] = '{0, 5, 6, 3, 7};
      logic [7:0]  s;
      logic [6:0]  off;
      logic [15:0] tg;
      logic        t;
      int          k;
      for (int j = 0; j < 56; j++) begin
         k   = 6 + j % 14;
         s   = pat[j / 14];
         off = j[0] ? 7'h40 : 7'h3F; // Both ends of the displacement range
         tg  = 16'h0020 + {{9{off[6]}}, off} + 16'h0001;
         if (k < 8) t = s[3'(j)] ^ k[0];
         else if (k < 10) t = s[2] ^ s[3] ^ !k[0];
         else t = s[fb[(k - 10) / 2]] ^ (k == 10 || (k > 11 && k[0]));
         run(bsls_op_t'(k), 8'h00, 8'h00, 3'(j), off, 1'b0, 16'h0000, s);
         chk(n, 1 + t);
         chk(nb, t);
         chk(pc_next, t ? tg : 16'h0021);
      end
      $display("branch test finished");
   endtask
   task automatic t_load();
      logic [15:0] ad [3] = '{16'h1234, 16'hFFFF, 16'h0000};
      logic [15:0] ea, np;
      logic [7:0]  dx;
      int          m;
      for (int j = 0; j < 3; j++) begin
         run(bsls_op_t'(20 + j), 8'h00, 8'h00, 3'h0, 7'h00, 1'b0, ad[j], 8'h00);
         // Wait for the one-cycle write-back and judge it while it stands
         m = 0;
         while (wb.valid !== 1'b1 && m < 4) begin
            @(posedge clk);
            #1 m++;
         end
         np = j == 1 ? ad[j] + 16'h0001 : ad[j] - 16'h0001; // Pointer wraps at both ends
         ea = j == 2 ? np : ad[j];
         dx = ea[7:0] ^ ea[15:8] ^ 8'hA5;
         chk(n, j == 1 ? 1 : 2);
         chk(nb, j == 1 ? 0 : 1);
         chk(nr, 1);
         chk(m, j == 1);
         chk(mem_addr, ea);
         chk({wb.valid, wb.dest, wb.data}, {1'b1, 5'h03, dx});
         chk({wb.ptr_we, j ? wb.ptr : 16'h0000}, {j != 0, j ? np : 16'h0000});
      end
      $display("load test finished");
   endtask
   task automatic conclude();
      $display("checks %0d mismatches %0d", checks_done, fail_count);
      if (fail_count == 0 && checks_done > 0) begin
         $display("DONE - PASS");
      end else begin
         $display("DONE - FAIL");
      end
      $finish;
   endtask
   initial begin
      {fail_count, checks_done, n} = '0;
      reset_n     = 1'b0;
      instr_valid = 1'b0;
      instr       = '0;
      sr          = 8'h00;
      repeat (6) @(posedge clk);
      reset_n <= 1'b1;
      t_skip();
      t_branch();
      t_load();
      conclude();
   end
endmodule
